// file: rtl/twb_defs.svh
// Constants for the two-wire bus flag handling block
`ifndef TWB_DEFS_SVH
`define TWB_DEFS_SVH
// ----------------------------------------
// Slave response command codes
// ----------------------------------------
`define TWB_CMD_NONE     2'h0
`define TWB_CMD_RESPOND  2'h3
// ----------------------------------------
// Status bit positions (write one to clear)
// ----------------------------------------
`define TWB_BIT_DATA     0
`define TWB_BIT_STOPADR  1
`define TWB_BIT_COLL     2
`define TWB_BIT_TIMEOUT  3
// ----------------------------------------
// Bus timeout: time in ns and derived count
// ----------------------------------------
`define TWB_CLK_NS       4
`define TWB_TIMEOUT_NS   100000
`define TWB_TIMEOUT_CYC  (`TWB_TIMEOUT_NS / `TWB_CLK_NS)
`endif

// file: rtl/twb_pkg.sv
// Types for the two-wire bus flag handling block
package twb_pkg;
  typedef enum logic [1:0] {TWB_IDLE, TWB_BUSY, TWB_OWNER} twb_bus_state_t;
  typedef struct packed {
    logic timeout;
    logic collision;
    logic stop_address_flag;
    logic data_flag;
  } twb_flags_t;
endpackage

// file: rtl/twb_two_wire_bus.sv
// Slave-side two-wire bus event detection and status flag handling
// Notes on behaviour
// R1 - Collision flag clears on a START, but not on a repeated START.
// R2 - Software clears the collision flag itself after the address event.
// R3 - Clearing stop/address flag as it sets for an address leaves clock held.
// R4 - Software clears stop/address only when idle or clock line is low.
// R5 - Timeout coinciding with START drops the transaction that START begins.
// R6 - Respond command clears the data flag one cycle later.
// R7 - Software waits one cycle after the respond command before testing.
// R8 - Only one instance exists; the second is absent.
// R9 - Hardware-set flags clear by writing one to their bit.
`timescale 1ns/1ps
`include "twb_defs.svh"
// R8 single instance, no second copy is built
module twb_two_wire_bus
  import twb_pkg::*;
#(
  parameter int TIMEOUT_CYC = `TWB_TIMEOUT_CYC
)
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // Bus pins (open drain)
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_scl_out,
  output logic             o_scl_oe_n,
  // Software control
  input  wire logic        i_timeout_en,
  input  wire logic        i_addr_match,
  input  wire logic        i_coll_event,
  input  wire logic        i_data_event,
  input  wire logic [1:0]  i_cmd,
  input  wire logic        i_cmd_wr,
  input  wire logic [3:0]  i_clear,
  // Status
  output twb_flags_t       o_flags,
  output logic             o_clock_hold_status,
  output twb_bus_state_t   o_bus_state,
  output logic             o_dropped
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic       scl_q;
  logic       sda_q;
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
    end
    else
    begin
      scl_sync <= {scl_sync[0], i_scl};
      sda_sync <= {sda_sync[0], i_sda};
      scl_q    <= scl_sync[1];
      sda_q    <= sda_sync[1];
    end
  end

  // ----------------------------------------
  // Bus condition decode
  // ----------------------------------------
  wire start_det = scl_sync[1] & scl_q & sda_q & ~sda_sync[1];
  wire stop_det  = scl_sync[1] & scl_q & ~sda_q & sda_sync[1];
  wire first_start = start_det & (o_bus_state == TWB_IDLE);
  logic [31:0] idle_cnt;
  wire timeout_hit = i_timeout_en && (idle_cnt == TIMEOUT_CYC - 1);
  wire scl_moved   = scl_sync[1] != scl_q;
  // Counter rests while detection is off, so an enable starts a fresh count
  wire cnt_clear   = scl_moved | timeout_hit | ~i_timeout_en;
  // Timeout on the START cycle drops the new transaction
  // R5 drop on coincidence
  wire drop_now = timeout_hit & start_det;
  wire addr_set = i_addr_match & ~o_dropped & (o_bus_state == TWB_OWNER);

  // ----------------------------------------
  // Bus state and timeout counter
  // ----------------------------------------
  twb_bus_state_t next_state;
  always_comb
  begin
    next_state = o_bus_state;
    if (stop_det || timeout_hit)
      next_state = TWB_IDLE;
    if (start_det && !drop_now)
      next_state = TWB_OWNER;
    else if (drop_now)
      next_state = TWB_BUSY;
  end
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_bus_state <= TWB_IDLE;
      idle_cnt    <= '0;
      o_dropped   <= 1'b0;
    end
    else
    begin
      o_bus_state <= next_state;
      idle_cnt    <= cnt_clear ? '0 : idle_cnt + 32'd1;
      o_dropped   <= drop_now ? 1'b1 : (start_det || stop_det) ? 1'b0 : o_dropped;
    end
  end

  // ----------------------------------------
  // Flags
  // ----------------------------------------
  logic resp_pend;
  wire  resp_cmd = i_cmd_wr && (i_cmd == `TWB_CMD_RESPOND);
  // R3 coincident set and clear keeps the hold
  wire  race = addr_set & i_clear[`TWB_BIT_STOPADR];
  // R9 write one to clear, set wins
  wire  next_timeout = timeout_hit | (o_flags.timeout & ~i_clear[`TWB_BIT_TIMEOUT]);
  // R1 cleared on first START only
  wire  next_collision = i_coll_event |
    (o_flags.collision & ~i_clear[`TWB_BIT_COLL] & ~first_start);
  wire  next_stop_address = addr_set | stop_det |
    (o_flags.stop_address_flag & ~i_clear[`TWB_BIT_STOPADR]);
  // R6 data flag clears a cycle after respond
  wire  next_data = i_data_event |
    (o_flags.data_flag & ~i_clear[`TWB_BIT_DATA] & ~resp_pend);
  wire  hold_set  = addr_set | (i_data_event & (o_bus_state == TWB_OWNER));
  wire  hold_clr  = (i_clear[`TWB_BIT_STOPADR] & ~race) | resp_pend | stop_det;
  wire  next_hold = hold_set | (o_clock_hold_status & ~hold_clr);
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_flags <= '0;
    end
    else
    begin
      o_flags <= {next_timeout, next_collision, next_stop_address, next_data};
    end
  end

  // ----------------------------------------
  // Clock hold and respond delay
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_clock_hold_status <= 1'b0;
      resp_pend           <= 1'b0;
    end
    else
    begin
      o_clock_hold_status <= next_hold;
      resp_pend           <= resp_cmd;
    end
  end

  // ----------------------------------------
  // Clock line drive: pulls low while held
  // ----------------------------------------
  assign o_scl_out  = 1'b0;
  assign o_scl_oe_n = ~o_clock_hold_status;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_data_clear_delay: assert property (@(posedge i_clk) disable iff (!i_nrst) // R6
    (resp_cmd && !i_data_event) ##1 !i_data_event
      |-> o_flags.data_flag == $past(o_flags.data_flag) ##1 !o_flags.data_flag)
    else $error("data flag not cleared one cycle after respond");

  a_data_still_set: assert property (@(posedge i_clk) disable iff (!i_nrst) // R6
    (resp_cmd && !resp_pend && o_flags.data_flag && !i_clear[`TWB_BIT_DATA])
      |=> o_flags.data_flag)
    else $error("data flag cleared too early after respond");

  a_coll_keep: assert property (@(posedge i_clk) disable iff (!i_nrst) // R1
    (o_flags.collision && start_det && o_bus_state != TWB_IDLE && !i_clear[`TWB_BIT_COLL])
      |=> o_flags.collision)
    else $error("collision cleared on repeated start");

  a_coll_first: assert property (@(posedge i_clk) disable iff (!i_nrst) // R1
    (first_start && !i_coll_event) |=> !o_flags.collision)
    else $error("collision kept over first start");

  a_flag_clear: assert property (@(posedge i_clk) disable iff (!i_nrst) // R9
    (i_clear[`TWB_BIT_TIMEOUT] && !timeout_hit) |=> !o_flags.timeout)
    else $error("timeout flag not cleared by write one");

  // ----------------------------------------
  // Assertions: bus state and clock hold
  // ----------------------------------------
  a_race_hold: assert property (@(posedge i_clk) disable iff (!i_nrst) // R3
    race |=> o_clock_hold_status)
    else $error("clock hold released on race");

  a_hold_release: assert property (@(posedge i_clk) disable iff (!i_nrst) // R3
    (o_clock_hold_status && i_clear[`TWB_BIT_STOPADR] && !i_addr_match && !i_data_event)
      |=> !o_clock_hold_status)
    else $error("clock hold kept after clean clear");

  a_drop_start: assert property (@(posedge i_clk) disable iff (!i_nrst) // R5
    drop_now |=> o_dropped && o_bus_state == TWB_BUSY)
    else $error("transaction not dropped");

  a_drop_refuse: assert property (@(posedge i_clk) disable iff (!i_nrst) // R5
    (o_dropped && i_addr_match && !o_clock_hold_status && !i_data_event)
      |=> !o_clock_hold_status)
    else $error("address taken in dropped transaction");

  a_timeout_idle: assert property (@(posedge i_clk) disable iff (!i_nrst) // R5
    (timeout_hit && !start_det) |=> o_bus_state == TWB_IDLE)
    else $error("bus not idle after timeout");
endmodule // twb_two_wire_bus

// file: bench/twb_bus_partner.sv
// Far-side bus master model issuing START, repeated START and STOP
`timescale 1ns/1ps
module twb_bus_partner
(
  // Open-drain drive, released to the pull-up level
  output logic o_scl,
  output logic o_sda
);
  initial
  begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic start();
    o_sda = 1'b1;
    #33 o_scl = 1'b1;
    #32 o_sda = 1'b0;
    #32 o_scl = 1'b0;
  endtask
  // lone falling data edge, timed by the bench
  task automatic fall_sda();
    o_sda = 1'b0;
  endtask
  task automatic stop();
    o_sda = 1'b0;
    #33 o_scl = 1'b1;
    #32 o_sda = 1'b1;
  endtask
endmodule // twb_bus_partner

// file: bench/twb_two_wire_bus_tb_top.sv
// Self-checking bench for the two-wire bus flag block
`timescale 1ns/1ps
`include "twb_defs.svh"
module twb_two_wire_bus_tb_top;
  import twb_pkg::*;
  logic           clk = 0, nrst = 0, coll = 0, dat = 0, cwr = 0, p_scl, p_sda;
  logic           am = 0, ten = 0;
  logic [3:0]     clr = 4'h0;
  logic [1:0]     cmd = `TWB_CMD_RESPOND;
  logic [31:0]    seed = 32'hbcd8;
  wire            scl_out, scl_oe_n, hold, dropped;
  twb_flags_t     flags;
  twb_bus_state_t bst;
  int             fails = 0, samples_checked = 0, cyc = 0;
  twb_two_wire_bus #(.TIMEOUT_CYC(20)) twb_two_wire_bus_inst (.i_clk(clk), .i_nrst(nrst),
    .i_scl(p_scl & scl_oe_n), .i_sda(p_sda), .o_scl_out(scl_out), .o_scl_oe_n(scl_oe_n),
    .i_timeout_en(ten), .i_addr_match(am), .i_coll_event(coll), .i_data_event(dat),
    .i_cmd(cmd), .i_cmd_wr(cwr), .i_clear(clr), .o_flags(flags),
    .o_clock_hold_status(hold), .o_bus_state(bst), .o_dropped(dropped));
  twb_bus_partner twb_bus_partner_inst (.o_scl(p_scl), .o_sda(p_sda));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial
    forever #2 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      wrap_up();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Pulse {coll, dat, cwr, clr} for one cycle
  task automatic drive(input logic [6:0] v);
    @(posedge clk);
    {coll, dat, cwr, clr} <= v;
    @(posedge clk);
    {coll, dat, cwr, clr} <= 7'h00;
  endtask
  task automatic settle();
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic wrap_up();
    $display("checks=%0d fails=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    repeat (4) @(posedge clk);
    #1 chk({scl_oe_n, hold, bst}, 4'h8);
    @(posedge clk);
    nrst <= 1'b1;
    drive(7'h40);
    settle();
    chk(flags, 4'h4);
    twb_bus_partner_inst.start();
    settle();
    chk(flags, 4'h0);
    drive(7'h40);
    twb_bus_partner_inst.start();
    settle();
    chk(flags, 4'h4);
    drive(7'h04);
    settle();
    chk(flags, 4'h0);
    drive(7'h44);
    settle();
    chk(flags, 4'h4);
    drive(7'h04);
    twb_bus_partner_inst.stop();
    settle();
    chk(flags, 4'h2);
    drive(7'h02);
    settle();
    chk(flags, 4'h0);
    for (int i = 0; i < 8; i++)
    begin
      seed = xs(seed);
      repeat (seed[4:1]) @(posedge clk);
      drive({seed[5], 6'h20});
      settle();
      chk(flags, {1'b0, seed[5], 2'b01});
      if (seed[0])
      begin
        drive(7'h10);
        #1 chk(flags, {1'b0, seed[5], 2'b01});
        @(posedge clk);
        #1 chk(flags, {1'b0, seed[5], 2'b00});
        drive(7'h04);
      end
      else
      begin
        drive(7'h05);
        settle();
        chk(flags, 4'h0);
      end
    end
    // Timeout lined up with a START on the same cycle
    @(posedge clk);
    ten <= 1'b1;
    wait (flags.timeout);
    repeat (17) @(posedge clk);
    #1 twb_bus_partner_inst.fall_sda();
    repeat (4) @(posedge clk);
    ten <= 1'b0;
    #1 chk({1'b0, dropped, bst}, 4'h5);
    chk(flags, 4'h8);
    @(posedge clk);
    am <= 1'b1;
    @(posedge clk);
    am <= 1'b0;
    settle();
    chk({1'b0, dropped, hold, flags.stop_address_flag}, 4'h4);
    drive(7'h08);
    twb_bus_partner_inst.start();
    settle();
    chk(flags, 4'h2);
    drive(7'h02);
    settle();
    chk(flags, 4'h0);
    // Address match and stop/address clear on one edge
    @(posedge clk);
    am  <= 1'b1;
    clr <= 4'h2;
    @(posedge clk);
    am  <= 1'b0;
    clr <= 4'h0;
    settle();
    chk(flags, 4'h2);
    chk({1'b0, scl_out, scl_oe_n, hold}, 4'h1);
    drive(7'h02);
    settle();
    chk({1'b0, scl_out, scl_oe_n, hold}, 4'h2);
    chk(flags, 4'h0);
    wrap_up();
  end
endmodule // twb_two_wire_bus_tb_top
